// [design/cdm_defs.svh]
`ifndef CDM_DEFS_SVH
`define CDM_DEFS_SVH

// mailbox count and bus geometry
`define CDM_NUM_MB          32
`define CDM_ADDR_W          12
`define CDM_DATA_W          32

// register byte offsets
`define CDM_OFS_ENABLE      12'h000
`define CDM_OFS_EXPIRED     12'h004
`define CDM_OFS_TSC         12'h008
`define CDM_OFS_STATUS      12'h00c
`define CDM_BASE_STAMP      12'h100
`define CDM_BASE_DEADLINE   12'h200
`define CDM_REGION_MASK     12'hf80

// status register fields
`define CDM_ST_TX_ACTIVE    0
`define CDM_ST_RX_ACTIVE    1
`define CDM_ST_GLOBAL_TO    2

// reset values
`define CDM_RST_ENABLE      32'h00000000
`define CDM_RST_EXPIRED     32'h00000000
`define CDM_RST_TSC         32'h00000000
`define CDM_RST_WORD        32'h00000000

`endif

// [design/cdm_pkg.sv]
package cdm_pkg;

    typedef logic [31:0] cdm_word_t;
    typedef logic [4:0]  cdm_idx_t;

    // one successful transmit or receive of a mailbox, single-cycle pulse
    typedef struct packed {
        logic     valid;
        cdm_idx_t index;
    } cdm_mb_event_s;

    // protocol kernel activity
    typedef struct packed {
        logic tx_active;
        logic rx_active;
        logic busy;
    } cdm_kernel_s;

    typedef enum logic {
        SCAN_FETCH,
        SCAN_COMPARE
    } cdm_scan_e;

endpackage

// [design/cdm_timestamp_counter.sv]
`timescale 1ns/100ps
`include "cdm_defs.svh"

module cdm_timestamp_counter #(
    parameter int W = 32
) (
    input  wire logic         i_clk,   // system clock
    input  wire logic         i_rst_n, // sync reset, active low
    input  wire logic         i_ce,    // clock enable
    input  wire logic         i_tick,  // one pulse per bit time
    input  wire logic         i_halt,  // init, sleep or suspend
    output logic     [W-1:0]  o_count  // running stamp value
);

    logic [W-1:0] next_count;

    // free-running up-count, wraps silently
    always_comb begin
        next_count = o_count;
        if (i_tick && !i_halt) begin // [R18]
            next_count = o_count + {{(W-1){1'b0}}, 1'b1}; // [R17]
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            o_count <= W'(`CDM_RST_TSC);
        end else if (i_ce) begin
            o_count <= next_count;
        end
    end

    a_tsc_holds_halted: assert property (@(posedge i_clk) disable iff (!i_rst_n) // [R18]
        i_ce && (i_halt || !i_tick) |=> $stable(o_count))
        else $error("stamp counter moved while halted or without tick");
    a_tsc_steps_one: assert property (@(posedge i_clk) disable iff (!i_rst_n) // [R17]
        i_ce && i_tick && !i_halt |=> o_count == W'($past(o_count) + 1))
        else $error("stamp counter did not step by one");

endmodule // cdm_timestamp_counter

// [design/cdm_deadline_monitor.sv]
// Design decisions made here: the APB slave port and the placing of the registers.
`timescale 1ns/100ps
`include "cdm_defs.svh"
// Functional notes
// [R1] each successful transfer copies the stamp counter into that mailbox's stamp
// [R2] every mailbox owns a deadline; missing it while enabled raises its expired flag
// [R3] transmit expired flag clears on enable clear or request falling
// [R4] receive expired flag clears when its enable clears
// [R5] writing one to an expired bit clears it; zero leaves it
// [R6] deadlines live in a RAM scanned mailbox by mailbox against the counter
// [R7] set only when counter >= deadline, enabled, and transmit request pending
// [R8] scan lag; request gone before scan reaches mailbox means no flag
// [R9] receive pending seen at scan time suppresses the expired flag
// [R10] enable bit low never lets the expired flag set
// [R11] software loads the deadline before setting the enable bit
// [R12] a time-out sets the global flag with the expired flag and raises the irq
// [R13] global flag clears with the flag when the causing mailbox completes
// [R14] interrupt handler tolerates an already cleared global flag
// [R15] status shows kernel transmit-active and receive-active
// [R16] software waits out activity, rechecks expired flag before retransmitting
// [R17] one free-running 32-bit up-counter feeds stamps and deadlines
// [R18] counter steps once per bit time, halts in init, sleep, suspend
// [R19] scanner yields to protocol kernel register traffic
// [R20] scanner cycles 0 to 31, one comparison per step, then wraps

module cdm_deadline_monitor (
    input  wire logic                    i_clk,          // system clock, 20 MHz
    input  wire logic                    i_rst_n,        // sync reset, active low
    input  wire logic                    i_ce,           // clock enable, freezes all
    input  wire logic                    i_psel,         // apb select
    input  wire logic                    i_penable,      // apb enable
    input  wire logic                    i_pwrite,       // apb direction
    input  wire logic [11:0]             i_paddr,        // apb byte address
    input  wire logic [31:0]             i_pwdata,       // apb write data
    output logic      [31:0]             o_prdata,       // apb read data
    output logic                         o_pready,       // apb ready
    output logic                         o_pslverr,      // apb error, unmapped
    input  wire cdm_pkg::cdm_mb_event_s  i_mb_done,      // mailbox transfer done
    input  wire logic [31:0]             i_mb_is_tx,     // mailbox direction, 1 = tx
    input  wire logic [31:0]             i_tx_request,   // transmit requests
    input  wire logic [31:0]             i_rx_pending,   // receive pending bits
    input  wire cdm_pkg::cdm_kernel_s    i_kernel,       // kernel activity
    input  wire logic                    i_bit_tick,     // bit time pulse
    input  wire logic                    i_tsc_halt,     // init, sleep, suspend
    output logic                         o_timeout_irq   // time-out irq request
);
    import cdm_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // declarations

    cdm_word_t  timestamp_counter;
    cdm_word_t  stamp_mem    [`CDM_NUM_MB];
    cdm_word_t  deadline_mem [`CDM_NUM_MB]; // [R2]
    cdm_word_t  enable;
    cdm_word_t  expired;
    cdm_word_t  tx_req_prev;
    cdm_word_t  scan_data;
    cdm_idx_t   scan_idx;
    cdm_idx_t   glob_cause;
    cdm_scan_e  scan_state;
    logic       glob_flag;

    cdm_word_t  next_enable;
    cdm_word_t  next_expired;
    cdm_word_t  next_scan_data;
    cdm_idx_t   next_scan_idx;
    cdm_idx_t   next_glob_cause;
    cdm_scan_e  next_scan_state;
    logic       next_glob_flag;
    cdm_word_t  next_prdata;
    logic       next_pready;
    logic       next_pslverr;

    logic       setup;
    logic       wr_fire;
    logic       scan_stall;
    logic       scan_hit;
    cdm_word_t  scan_set;
    cdm_word_t  done_vec;
    cdm_word_t  tx_fall;
    cdm_word_t  sw_clr;
    cdm_word_t  auto_clr;

    ////////////////////////////////////////////////////////////////////////////
    // address decode helpers

    function automatic logic in_region(input logic [11:0] a, input logic [11:0] base);
        return (a & `CDM_REGION_MASK) == base;
    endfunction

    function automatic logic is_mapped(input logic [11:0] a);
        return (a == `CDM_OFS_ENABLE) || (a == `CDM_OFS_EXPIRED) ||
               (a == `CDM_OFS_TSC) || (a == `CDM_OFS_STATUS) ||
               (in_region(a, `CDM_BASE_STAMP) && a[1:0] == 2'h0) ||
               (in_region(a, `CDM_BASE_DEADLINE) && a[1:0] == 2'h0);
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // stamp counter

    cdm_timestamp_counter #(
        .W (32)
    ) u_tsc (
        .i_clk   (i_clk),
        .i_rst_n (i_rst_n),
        .i_ce    (i_ce),
        .i_tick  (i_bit_tick),
        .i_halt  (i_tsc_halt),
        .o_count (timestamp_counter)
    );

    ////////////////////////////////////////////////////////////////////////////
    // apb slave: answer in the first access cycle, data registered at setup

    assign setup   = i_psel && !i_penable;
    // an errored access (unmapped or misaligned) must never land anywhere
    assign wr_fire = i_psel && i_penable && o_pready && i_pwrite && !o_pslverr;

    // read mux sampled in setup so prdata comes from a flop
    always_comb begin
        next_prdata  = o_prdata;
        next_pready  = setup;
        next_pslverr = 1'b0;
        if (setup) begin
            next_pslverr = !is_mapped(i_paddr);
            next_prdata  = `CDM_RST_WORD;
            if (!i_pwrite) begin
                if (i_paddr == `CDM_OFS_ENABLE) begin
                    next_prdata = enable;
                end else if (i_paddr == `CDM_OFS_EXPIRED) begin
                    next_prdata = expired;
                end else if (i_paddr == `CDM_OFS_TSC) begin
                    next_prdata = timestamp_counter;
                end else if (i_paddr == `CDM_OFS_STATUS) begin
                    next_prdata[`CDM_ST_TX_ACTIVE] = i_kernel.tx_active; // [R15]
                    next_prdata[`CDM_ST_RX_ACTIVE] = i_kernel.rx_active; // [R15]
                    next_prdata[`CDM_ST_GLOBAL_TO] = glob_flag;
                end else if (in_region(i_paddr, `CDM_BASE_STAMP)) begin
                    next_prdata = stamp_mem[i_paddr[6:2]];
                end else if (in_region(i_paddr, `CDM_BASE_DEADLINE)) begin
                    next_prdata = deadline_mem[i_paddr[6:2]];
                end
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            o_prdata  <= `CDM_RST_WORD;
            o_pready  <= 1'b0;
            o_pslverr <= 1'b0;
        end else if (i_ce) begin
            o_prdata  <= next_prdata;
            o_pready  <= next_pready;
            o_pslverr <= next_pslverr;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // stamp capture and deadline ram; kernel capture beats a cpu write

    always_ff @(posedge i_clk) begin
        if (i_ce) begin
            for (int n = 0; n < `CDM_NUM_MB; n++) begin
                if (i_mb_done.valid && i_mb_done.index == cdm_idx_t'(n)) begin
                    stamp_mem[n] <= timestamp_counter; // [R1]
                end else if (wr_fire && in_region(i_paddr, `CDM_BASE_STAMP) &&
                             i_paddr[6:2] == cdm_idx_t'(n)) begin
                    stamp_mem[n] <= i_pwdata;
                end
            end
            if (wr_fire && in_region(i_paddr, `CDM_BASE_DEADLINE)) begin
                deadline_mem[i_paddr[6:2]] <= i_pwdata; // [R6]
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // deadline scanner: fetch one word, compare, move on

    // yields to kernel traffic and to a cpu write into the ram
    assign scan_stall = i_kernel.busy ||
                        (wr_fire && in_region(i_paddr, `CDM_BASE_DEADLINE)); // [R19]

    // request or pending bit is looked at only now, so late success wins
    assign scan_hit = (scan_state == SCAN_COMPARE) && !scan_stall &&
                      enable[scan_idx] && // [R10]
                      (timestamp_counter >= scan_data) && // [R7]
                      (i_mb_is_tx[scan_idx] ? i_tx_request[scan_idx] // [R8]
                                            : !i_rx_pending[scan_idx]); // [R9]

    assign scan_set = scan_hit ? (32'h00000001 << scan_idx) : 32'h00000000;

    always_comb begin
        next_scan_state = scan_state;
        next_scan_idx   = scan_idx;
        next_scan_data  = scan_data;
        if (!scan_stall) begin
            case (scan_state)
                SCAN_FETCH: begin
                    next_scan_data  = deadline_mem[scan_idx]; // [R6]
                    next_scan_state = SCAN_COMPARE;
                end
                SCAN_COMPARE: begin
                    next_scan_idx   = scan_idx + 5'h01; // [R20]
                    next_scan_state = SCAN_FETCH;
                end
                default: begin
                    next_scan_state = SCAN_FETCH;
                end
            endcase
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            scan_state <= SCAN_FETCH;
            scan_idx   <= 5'h00;
            scan_data  <= `CDM_RST_WORD;
        end else if (i_ce) begin
            scan_state <= next_scan_state;
            scan_idx   <= next_scan_idx;
            scan_data  <= next_scan_data;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // enable, expired and global flags; a set always wins over a clear

    assign done_vec = i_mb_done.valid ? (32'h00000001 << i_mb_done.index) : 32'h00000000;
    assign tx_fall  = i_mb_is_tx & tx_req_prev & ~i_tx_request; // [R3]
    assign sw_clr   = (wr_fire && i_paddr == `CDM_OFS_EXPIRED) ? i_pwdata
                                                               : 32'h00000000; // [R5]
    // disabled mailboxes drop the flag, whichever direction
    assign auto_clr = ~enable | tx_fall | done_vec; // [R3] [R4] [R13]

    always_comb begin
        next_enable = enable;
        if (wr_fire && i_paddr == `CDM_OFS_ENABLE) begin
            next_enable = i_pwdata;
        end
        next_expired    = scan_set | (expired & ~(sw_clr | auto_clr)); // [R2] [R5]
        next_glob_cause = scan_hit ? scan_idx : glob_cause;
        next_glob_flag  = glob_flag;
        if (scan_hit) begin
            next_glob_flag = 1'b1; // [R12]
        end else if ((wr_fire && i_paddr == `CDM_OFS_STATUS &&
                      i_pwdata[`CDM_ST_GLOBAL_TO]) ||
                     done_vec[glob_cause] || tx_fall[glob_cause]) begin
            next_glob_flag = 1'b0; // [R13]
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            enable      <= `CDM_RST_ENABLE;
            expired     <= `CDM_RST_EXPIRED;
            tx_req_prev <= `CDM_RST_WORD;
            glob_cause  <= 5'h00;
            glob_flag   <= 1'b0;
        end else if (i_ce) begin
            enable      <= next_enable;
            expired     <= next_expired;
            tx_req_prev <= i_tx_request;
            glob_cause  <= next_glob_cause;
            glob_flag   <= next_glob_flag;
        end
    end

    // irq line is the global flag flop itself
    assign o_timeout_irq = glob_flag; // [R12]

    ////////////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);

    a_stamp_capture: assert property ( // [R1]
        i_ce && i_mb_done.valid |=> stamp_mem[$past(i_mb_done.index)] == $past(timestamp_counter))
        else $error("capture stamp missed the counter value");
    a_set_needs_enable: assert property ( // [R10]
        i_ce |=> (expired & ~$past(expired) & ~$past(enable)) == 32'h00000000)
        else $error("expired flag set while its enable was low");
    a_sw_clear_one: assert property ( // [R5]
        i_ce && wr_fire && i_paddr == `CDM_OFS_EXPIRED |=>
        (expired & $past(i_pwdata) & ~$past(scan_set)) == 32'h00000000)
        else $error("write of one did not clear an expired flag");
    a_disable_clears: assert property ( // [R4]
        i_ce |=> (expired & ~$past(enable) & ~$past(scan_set)) == 32'h00000000)
        else $error("expired flag survived a cleared enable");
    a_tx_fall_clears: assert property ( // [R3]
        i_ce |=> (expired & $past(tx_fall) & ~$past(scan_set)) == 32'h00000000)
        else $error("expired flag survived a dropped transmit request");
    a_flag_with_irq: assert property ( // [R12]
        i_ce && scan_hit |=> o_timeout_irq && expired[$past(scan_idx)])
        else $error("time-out did not raise both flags");
    a_scan_wraps: assert property ( // [R20]
        i_ce && scan_state == SCAN_COMPARE && !scan_stall && scan_idx == 5'h1f |=>
        scan_idx == 5'h00 ##0 scan_state == SCAN_FETCH)
        else $error("scanner did not wrap to mailbox zero");
    a_kernel_stalls: assert property ( // [R19]
        i_ce && i_kernel.busy |=> $stable(scan_idx) && $stable(scan_state))
        else $error("scanner moved during kernel traffic");
    a_hit_needs_req: assert property ( // [R7]
        scan_hit |-> timestamp_counter >= scan_data && (!i_mb_is_tx[scan_idx] || i_tx_request[scan_idx]))
        else $error("time-out taken without expiry or pending request");
    a_apb_ready: assert property (
        i_ce && setup |=> o_pready)
        else $error("apb access phase not answered");

endmodule // cdm_deadline_monitor

// [verif/cdm_kernel_model.sv]
`timescale 1ns/100ps
////////////////////////////////////////////////////////////////////////////////
// stand-in for the protocol kernel and the bit clock
module cdm_kernel_model (
    input  wire logic              i_clk,        // system clock
    output cdm_pkg::cdm_mb_event_s o_mb_done,    // completion pulse
    output logic [31:0]            o_is_tx,      // direction, 1 = tx
    output logic [31:0]            o_tx_request, // pending sends
    output logic [31:0]            o_rx_pending, // unread receptions
    output cdm_pkg::cdm_kernel_s   o_kernel,     // activity levels
    output logic                   o_bit_tick    // bit time pulse
);
    import cdm_pkg::*;
    // mailboxes 9 and 10 receive, the rest transmit
    initial begin
        o_mb_done = '0;
        o_is_tx = 32'hffff_f9ff;
        o_tx_request = '0;
        o_rx_pending = '0;
        o_kernel = '0;
        o_bit_tick = 1'b0;
    end
    // ticks only on demand, so stamp values stay predictable
    task automatic tick(input int n);
        @(posedge i_clk);
        o_bit_tick <= 1'b1;
        repeat (n) @(posedge i_clk);
        o_bit_tick <= 1'b0;
    endtask
    // a frame on the wire, then the completion pulse and status updates
    task automatic done(input cdm_idx_t idx);
        @(posedge i_clk);
        o_kernel.tx_active <= o_is_tx[idx];
        o_kernel.rx_active <= !o_is_tx[idx];
        repeat (3) @(posedge i_clk);
        o_mb_done <= '{valid: 1'b1, index: idx};
        o_kernel.tx_active <= 1'b0;
        o_kernel.rx_active <= 1'b0;
        o_tx_request[idx] <= 1'b0;
        o_rx_pending[idx] <= !o_is_tx[idx];
        @(posedge i_clk);
        o_mb_done.valid <= 1'b0;
    endtask
endmodule // cdm_kernel_model

// [verif/can_mailbox_deadline_monitor_tb.sv]
`timescale 1ns/100ps
`include "cdm_defs.svh"
module can_mailbox_deadline_monitor_tb;
    import cdm_pkg::*;
    logic          i_clk = 1'b0;
    logic          i_rst_n = 1'b0;
    logic          psel = 1'b0;
    logic          penable = 1'b0;
    logic          pwrite = 1'b0;
    logic [11:0]   paddr = '0;
    cdm_word_t     pwdata = '0;
    logic          halt = 1'b0;
    logic          ce = 1'b1;
    cdm_word_t     prdata;
    logic          pready, pslverr, irq, tick;
    cdm_mb_event_s mb_done;
    cdm_kernel_s   kernel;
    logic [31:0]   is_tx, tx_req, rx_pend;
    int            n_mismatch = 0;
    int            tests_run = 0;
    // 20 MHz
    always #25 i_clk = ~i_clk;
    cdm_deadline_monitor dut_u (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_ce(ce),
        .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr),
        .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
        .i_mb_done(mb_done), .i_mb_is_tx(is_tx), .i_tx_request(tx_req),
        .i_rx_pending(rx_pend), .i_kernel(kernel), .i_bit_tick(tick),
        .i_tsc_halt(halt), .o_timeout_irq(irq));
    cdm_kernel_model kern_u (.i_clk(i_clk), .o_mb_done(mb_done), .o_is_tx(is_tx),
        .o_tx_request(tx_req), .o_rx_pending(rx_pend), .o_kernel(kernel),
        .o_bit_tick(tick));
    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input cdm_word_t got, input cdm_word_t exp, input string what);
        tests_run++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    // one apb transfer; waits for pready rather than assuming a latency
    task automatic apb(input logic w, input logic [11:0] a, input cdm_word_t d,
                       output cdm_word_t r, output logic e);
        int n = 0;
        @(posedge i_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge i_clk);
        penable <= 1'b1;
        do begin
            @(posedge i_clk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        chk(32'(n < 16), 32'h1, "pready");
    endtask
    task automatic wr(input logic [11:0] a, input cdm_word_t d);
        cdm_word_t r;
        logic e;
        apb(1'b1, a, d, r, e);
    endtask
    task automatic rd(input logic [11:0] a, output cdm_word_t r);
        logic e;
        apb(1'b0, a, '0, r, e);
    endtask
    task automatic rdc(input logic [11:0] a, input cdm_word_t exp, input string what);
        cdm_word_t r;
        rd(a, r);
        chk(r, exp, what);
    endtask
    // bounded wait for the interrupt line to reach a level
    task automatic wait_irq(input logic exp);
        int n = 0;
        while (irq !== exp && n < 300) begin
            @(posedge i_clk);
            n++;
        end
        chk(32'(irq), 32'(exp), "irq");
    endtask
    function automatic logic [11:0] dl(input int n);
        return `CDM_BASE_DEADLINE + 12'(4 * n);
    endfunction
    ////////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        cdm_word_t r;
        logic e;
        rdc(`CDM_OFS_ENABLE, `CDM_RST_ENABLE, "enable");
        rdc(`CDM_OFS_EXPIRED, 32'h0, "expired");
        rdc(`CDM_OFS_TSC, 32'h0, "counter");
        rdc(`CDM_OFS_STATUS, 32'h0, "status");
        apb(1'b0, 12'h080, '0, r, e);
        chk(32'(e), 32'h1, "unmapped err");
        chk(r, 32'h0, "unmapped data");
    endtask
    // counter steps per tick and freezes while halted
    task automatic t_count();
        cdm_word_t r;
        logic e;
        kern_u.tick(10);
        rdc(`CDM_OFS_TSC, 32'd10, "count");
        halt <= 1'b1;
        kern_u.tick(5);
        rdc(`CDM_OFS_TSC, 32'd10, "halted");
        halt <= 1'b0;
        kern_u.done(3);
        rdc(`CDM_BASE_STAMP + 12'd12, 32'd10, "stamp");
        wr(`CDM_BASE_STAMP + 12'd16, 32'h5a5a_0004);
        rdc(`CDM_BASE_STAMP + 12'd16, 32'h5a5a_0004, "stamp rw");
        // misaligned write decodes to stamp 4 but must be refused
        apb(1'b1, `CDM_BASE_STAMP + 12'h011, 32'h0, r, e);
        chk(32'(e), 32'h1, "misaligned err");
        rdc(`CDM_BASE_STAMP + 12'd16, 32'h5a5a_0004, "misaligned kept");
    endtask
    // tx time-out, then completion auto-clears flag and irq
    task automatic t_tx();
        cdm_word_t r;
        wr(dl(5), 32'd10);
        kern_u.o_tx_request[5] <= 1'b1;
        wr(`CDM_OFS_ENABLE, 32'h20);
        wait_irq(1'b1);
        rdc(`CDM_OFS_EXPIRED, 32'h20, "tx expired");
        rd(`CDM_OFS_STATUS, r);
        chk(32'(r[2]), 32'h1, "global set");
        kern_u.done(5);
        // handler side: check kernel activity has already ended, then look at the flag again
        rd(`CDM_OFS_STATUS, r);
        chk(32'(r[1:0]), 32'h0, "kernel idle");
        rdc(`CDM_OFS_EXPIRED, 32'h0, "tx done");
        chk(32'(irq), 32'h0, "irq auto");
        rd(`CDM_OFS_STATUS, r);
        chk(32'(r[2]), 32'h0, "late isr");
    endtask
    // aborted request clears the flag
    task automatic t_abort();
        wr(dl(6), 32'd10);
        kern_u.o_tx_request[6] <= 1'b1;
        wr(`CDM_OFS_ENABLE, 32'h60);
        wait_irq(1'b1);
        rdc(`CDM_OFS_EXPIRED, 32'h40, "abort set");
        kern_u.o_tx_request[6] <= 1'b0;
        repeat (2) @(posedge i_clk);
        rdc(`CDM_OFS_EXPIRED, 32'h0, "abort clr");
        wr(`CDM_OFS_STATUS, 32'h4);
        wait_irq(1'b0);
    endtask
    // one below the deadline, disabled, rx pending, no request: all quiet
    task automatic t_quiet();
        wr(dl(7), 32'd11);
        wr(dl(8), 32'd0);
        wr(dl(9), 32'd0);
        wr(dl(11), 32'd0);
        kern_u.o_tx_request[8:7] <= 2'b11;
        kern_u.o_rx_pending[9] <= 1'b1;
        wr(`CDM_OFS_ENABLE, 32'h0a80);
        repeat (200) @(posedge i_clk);
        rdc(`CDM_OFS_EXPIRED, 32'h0, "quiet");
        kern_u.tick(1);
        wait_irq(1'b1);
        rdc(`CDM_OFS_EXPIRED, 32'h80, "equal");
        kern_u.done(7);
        wait_irq(1'b0);
    endtask
    // rx mailbox; kernel busy holds the scanner off; software clears global
    task automatic t_rx();
        wr(dl(10), 32'd0);
        kern_u.o_kernel.busy <= 1'b1;
        wr(`CDM_OFS_ENABLE, 32'h400);
        repeat (200) @(posedge i_clk);
        rdc(`CDM_OFS_EXPIRED, 32'h0, "stalled");
        kern_u.o_kernel.busy <= 1'b0;
        wait_irq(1'b1);
        rdc(`CDM_OFS_EXPIRED, 32'h400, "rx set");
        kern_u.o_kernel.busy <= 1'b1;
        wr(`CDM_OFS_EXPIRED, 32'hffff_fbff);
        rdc(`CDM_OFS_EXPIRED, 32'h400, "w0 keeps");
        wr(`CDM_OFS_EXPIRED, 32'h400);
        rdc(`CDM_OFS_EXPIRED, 32'h0, "w1 clears");
        kern_u.o_kernel.busy <= 1'b0;
        repeat (140) @(posedge i_clk);
        rdc(`CDM_OFS_EXPIRED, 32'h400, "rescan");
        wr(`CDM_OFS_ENABLE, 32'h0);
        rdc(`CDM_OFS_EXPIRED, 32'h0, "rx off");
        chk(32'(irq), 32'h1, "global held");
        wr(`CDM_OFS_STATUS, 32'h4);
        wait_irq(1'b0);
    endtask
    // clock enable low freezes counter and scanner; mailbox 12 made a receiver
    task automatic t_freeze();
        kern_u.o_is_tx[12] <= 1'b0;
        wr(dl(12), 32'd0);
        wr(`CDM_OFS_ENABLE, 32'h1000);
        ce <= 1'b0;
        kern_u.tick(4);
        repeat (100) @(posedge i_clk);
        chk(32'(irq), 32'h0, "frozen irq");
        ce <= 1'b1;
        rdc(`CDM_OFS_TSC, 32'd11, "frozen count");
        wait_irq(1'b1);
        rdc(`CDM_OFS_EXPIRED, 32'h1000, "rx no request");
        wr(`CDM_OFS_ENABLE, 32'h0);
        wr(`CDM_OFS_STATUS, 32'h4);
        wait_irq(1'b0);
        kern_u.o_is_tx[12] <= 1'b1;
    endtask
    // every combination of the activity bits
    task automatic t_status();
        cdm_word_t r;
        for (int k = 0; k < 4; k++) begin
            kern_u.o_kernel <= cdm_kernel_s'({k[1:0], 1'b0});
            rd(`CDM_OFS_STATUS, r);
            chk(32'(r[1:0]), 32'({k[0], k[1]}), "activity");
        end
    endtask
    ////////////////////////////////////////////////////////////////////////////
    task automatic end_of_test();
        $display("TB: %0d checks, %0d mismatches", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    // hang guard, well past the thousand-odd cycles the run needs
    initial begin
        repeat (20000) @(posedge i_clk);
        n_mismatch++;
        end_of_test();
    end
    initial begin
        repeat (12) @(posedge i_clk);
        i_rst_n <= 1'b1;
        t_reset();
        t_count();
        t_tx();
        t_abort();
        t_quiet();
        t_rx();
        t_freeze();
        t_status();
        end_of_test();
    end
endmodule // can_mailbox_deadline_monitor_tb
